// >>> rtl/tbde_engine.sv
// Transmit buffer descriptor engine with its control registers
//
// How it works
// - After a buffer is sent or fails, clear its ready bit.
// - A descriptor with ready clear is not sent.
// - After the wrap descriptor, continue at the table base.
// - Interrupt-request bit set produces the done event; clear produces none.
// - Last bit marks the final buffer of the frame.
// - CRC-select counts only on a last buffer in HDLC mode.
// - At frame end send CRC then flag, or the flag alone.
// - Continuous bit keeps ready set after an error-free send so the buffer is resent.
// - The user bit is never written by the engine.
// - Pad count gives pad characters after the flag, 0x7E or 0xFF.
// - Done event only after all pads are pushed.
// - Pad count zero gives the event right after the closing flag.
// - Event follows the closing flag and its trailing pad characters.
// - Byte count sets how many bytes go; never written back.
// - A variant numbers descriptor bits in reverse order.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tbde_params.svh"
module tbde_engine #(
	parameter int ADDR_W = 32 // Width of memory addresses
) (
	input  wire logic              clk_sys,   // System clock
	input  wire logic              rst,       // Synchronous reset, active high
	input  wire logic [31:0]       s_awaddr,  // Write address
	input  wire logic              s_awvalid, // Write address valid
	output logic                   s_awready, // Write address taken
	input  wire logic [31:0]       s_wdata,   // Write data
	input  wire logic [3:0]        s_wstrb,   // Write byte strobes
	input  wire logic              s_wvalid,  // Write data valid
	output logic                   s_wready,  // Write data taken
	output logic [1:0]             s_bresp,   // Write response
	output logic                   s_bvalid,  // Write response valid
	input  wire logic              s_bready,  // Write response taken
	input  wire logic [31:0]       s_araddr,  // Read address
	input  wire logic              s_arvalid, // Read address valid
	output logic                   s_arready, // Read address taken
	output logic [31:0]            s_rdata,   // Read data
	output logic [1:0]             s_rresp,   // Read response
	output logic                   s_rvalid,  // Read data valid
	input  wire logic              s_rready,  // Read data taken
	output logic                   memReq,    // Memory access pending
	output logic                   memWrite,  // Access is a write
	output logic [ADDR_W-1:0]      memAddr,   // Word-aligned address
	output logic [31:0]            memWdata,  // Write data
	output logic [3:0]             memBe,     // Write byte enables
	input  wire logic              memAck,    // Access done
	input  wire logic [31:0]       memRdata,  // Read data, valid with ack
	input  wire logic              memErr,    // Access failed, with ack
	output logic                   txValid,   // Byte offered to transmit FIFO
	output logic [7:0]             txByte,    // Byte to transmit
	input  wire logic              txReady,   // FIFO takes the byte
	output logic                   evtValid,  // Transmit-done event, one cycle
	output logic [ADDR_W-1:0]      evtAddr    // Descriptor that caused it
);
	import tbde_pkg::*;

	tbde_state_t       state;
	tbde_state_t       next_state;
	logic [3:0]        ctrl;
	logic [31:0]       descriptor_table_base;
	logic [31:0]       curPtr;
	logic [31:0]       bufPtr;
	logic [31:0]       desc0Raw;
	logic [15:0]       bytesLeft;
	logic [3:0]        padLeft;
	logic [7:0]        pollCnt;
	logic [31:0]       evCount;
	logic              errFlag;
	logic              errBuf;
	logic              wrapFlag;
	logic              irqFlag;
	logic              lastFlag;
	logic              crcSel;
	logic              contFlag;
	logic [15:0]       fcs;

	// Byte lane of a little-endian word
	function automatic logic [7:0] laneByte(input logic [31:0] w, input logic [1:0] lane);
		laneByte = w[8 * lane +: 8];
	endfunction : laneByte

	// Control fields and decoded descriptor word
	wire        enable    = ctrl[`TBDE_CTRL_ENABLE];
	wire        hdlcMode  = ctrl[`TBDE_CTRL_HDLC];
	wire        revBits   = ctrl[`TBDE_CTRL_REVBITS];
	wire [7:0]  padChar   = ctrl[`TBDE_CTRL_IDLE] ? `TBDE_IDLE_ONES : `TBDE_FLAG_CHAR;
	wire [31:0] d0        = revBits ? {<<{memRdata}} : memRdata;
	wire        d0Ready   = d0[`TBDE_BD_READY];
	wire [31:0] readyMask = revBits ? 32'h8000_0000 : 32'h0000_0001;
	wire [3:0]  readyBe   = revBits ? 4'h8 : 4'h1;
	wire        txTaken   = txValid && txReady;
	wire        lastByte  = bytesLeft == 16'h0001;
	// Frame end only on a last buffer in HDLC mode; CRC-select ignored elsewhere
	wire        frameEnd  = hdlcMode && lastFlag;
	wire        wantCrc   = frameEnd && crcSel;

	// AXI4-Lite decode
	wire        wrGo   = s_awvalid && s_wvalid && !s_awready && !s_bvalid;
	wire        rdGo   = s_arvalid && !s_arready && !s_rvalid;
	wire        wrCtrl = wrGo && s_awaddr[7:0] == `TBDE_OFS_CTRL;
	wire        wrBase = wrGo && s_awaddr[7:0] == `TBDE_OFS_DESCRIPTOR_TABLE_BASE;
	wire        wrStat = wrGo && s_awaddr[7:0] == `TBDE_OFS_STATUS;
	wire        wrHit  = wrCtrl || wrBase || wrStat;
	wire        rdHit  = s_araddr[7:0] == `TBDE_OFS_CTRL || s_araddr[7:0] == `TBDE_OFS_DESCRIPTOR_TABLE_BASE
		|| s_araddr[7:0] == `TBDE_OFS_STATUS || s_araddr[7:0] == `TBDE_OFS_CURPTR
		|| s_araddr[7:0] == `TBDE_OFS_EVCNT;
	wire [31:0] rdMux  = (s_araddr[7:0] == `TBDE_OFS_CTRL)   ? {28'h0, ctrl} :
	               (s_araddr[7:0] == `TBDE_OFS_DESCRIPTOR_TABLE_BASE)  ? descriptor_table_base :
	               (s_araddr[7:0] == `TBDE_OFS_STATUS) ? {15'h0, errFlag, 5'h0, state} :
	               (s_araddr[7:0] == `TBDE_OFS_CURPTR) ? curPtr :
	               (s_araddr[7:0] == `TBDE_OFS_EVCNT)  ? evCount : 32'h0;

	// Register writes; a new error wins over a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl    <= `TBDE_CTRL_RST;
			descriptor_table_base   <= `TBDE_DESCRIPTOR_TABLE_BASE_RST;
			errFlag <= 1'b0;
		end else begin
			if (wrCtrl && s_wstrb[0]) ctrl <= s_wdata[3:0];
			if (wrBase) descriptor_table_base <= {s_wdata[31:3], 3'h0};
			if (memAck && memErr) errFlag <= 1'b1;
			else if (wrStat && s_wstrb[2] && s_wdata[`TBDE_STAT_ERR]) errFlag <= 1'b0;
		end
	end

	// Write channel handshake and response
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_awready <= 1'b0;
			s_wready  <= 1'b0;
			s_bvalid  <= 1'b0;
			s_bresp   <= 2'h0;
		end else begin
			s_awready <= wrGo;
			s_wready  <= wrGo;
			if (wrGo) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wrHit ? 2'h0 : 2'h2;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Read channel handshake and data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0;
			s_rresp   <= 2'h0;
		end else begin
			s_arready <= rdGo;
			if (rdGo) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rdMux;
				s_rresp  <= rdHit ? 2'h0 : 2'h2;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// Next state of the descriptor walk
	always_comb begin
		next_state = state;
		case (state)
			TBDE_IDLE: begin
				if (enable && pollCnt == 8'h00) next_state = TBDE_DESC0;
			end
			TBDE_DESC0: begin
				if (memAck) begin
					if (memErr || !d0Ready) next_state = TBDE_IDLE;
					else next_state = TBDE_DESC1;
				end
			end
			TBDE_DESC1: begin
				if (memAck) next_state = memErr ? TBDE_CLOSE : TBDE_DATA;
			end
			TBDE_DATA: begin
				if (memAck) next_state = memErr ? TBDE_CLOSE : TBDE_PUSH;
			end
			TBDE_PUSH: begin
				if (txTaken && !lastByte) next_state = TBDE_DATA;
				else if (txTaken) next_state = wantCrc ? TBDE_CRCLO :
					(frameEnd ? TBDE_FLAG : TBDE_CLOSE);
			end
			TBDE_CRCLO: begin
				if (txTaken) next_state = TBDE_CRCHI;
			end
			TBDE_CRCHI: begin
				if (txTaken) next_state = TBDE_FLAG;
			end
			TBDE_FLAG: begin
				if (txTaken) next_state = (padLeft == 4'h0) ? TBDE_CLOSE : TBDE_PAD;
			end
			TBDE_PAD: begin
				if (txTaken && padLeft == 4'h1) next_state = TBDE_CLOSE;
			end
			TBDE_CLOSE: begin
				if (memAck || !memReq) next_state = TBDE_EVENT;
			end
			TBDE_EVENT: begin
				next_state = TBDE_IDLE;
			end
			default: begin
				next_state = TBDE_IDLE;
			end
		endcase
	end

	// Walk state, descriptor fields and pointers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state     <= TBDE_IDLE;
			curPtr    <= 32'h0;
			bufPtr    <= 32'h0;
			desc0Raw  <= 32'h0;
			bytesLeft <= 16'h0;
			padLeft   <= 4'h0;
			pollCnt   <= 8'h00;
			errBuf    <= 1'b0;
			{wrapFlag, irqFlag, lastFlag, crcSel, contFlag} <= 5'h0;
		end else begin
			state <= next_state;
			if (!enable) curPtr <= descriptor_table_base;
			if (state == TBDE_IDLE && pollCnt != 8'h00) pollCnt <= pollCnt - 8'h01;
			if (state == TBDE_DESC0 && memAck) begin
				desc0Raw  <= memRdata;
				errBuf    <= 1'b0;
				pollCnt   <= `TBDE_POLL_CYCLES;
				wrapFlag  <= d0[`TBDE_BD_WRAP];
				irqFlag   <= d0[`TBDE_BD_IRQ];
				lastFlag  <= d0[`TBDE_BD_LAST];
				crcSel    <= d0[`TBDE_BD_CRCSEL];
				contFlag  <= d0[`TBDE_BD_CONT];
				padLeft   <= d0[`TBDE_BD_PAD_LO +: 4];
				bytesLeft <= d0[`TBDE_BD_LEN_LO +: 16];
			end
			if (state == TBDE_DESC1 && memAck) bufPtr <= memRdata;
			if ((state == TBDE_DESC1 || state == TBDE_DATA) && memAck && memErr) errBuf <= 1'b1;
			if (state == TBDE_PUSH && txTaken) begin
				bufPtr    <= bufPtr + 32'h1;
				bytesLeft <= bytesLeft - 16'h1;
			end
			if (state == TBDE_PAD && txTaken) padLeft <= padLeft - 4'h1;
			if (state == TBDE_EVENT) begin
				curPtr <= wrapFlag ? descriptor_table_base : curPtr + `TBDE_BD_BYTES;
				pollCnt <= 8'h00;
			end
		end
	end

	// Next access, raised at the edge that enters the state waiting for it
	wire        reqDesc0 = state == TBDE_IDLE && next_state == TBDE_DESC0;
	wire        reqDesc1 = state == TBDE_DESC0 && next_state == TBDE_DESC1;
	wire        reqData  = next_state == TBDE_DATA && state != TBDE_DATA;
	wire        reqClose = next_state == TBDE_CLOSE && state != TBDE_CLOSE
		&& (!contFlag || errBuf || memErr);
	wire [31:0] word1Ptr = curPtr + `TBDE_PTR_WORD;
	wire [31:0] nextPtr  = (state == TBDE_DESC1) ? memRdata : bufPtr + 32'h1;
	wire [31:0] readAddr = reqDesc0 ? curPtr : reqDesc1 ? word1Ptr : {nextPtr[31:2], 2'h0};

	// Memory requests: held until acknowledged; a new one has priority over the release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			memReq   <= 1'b0;
			memWrite <= 1'b0;
			memAddr  <= '0;
			memWdata <= 32'h0;
			memBe    <= 4'h0;
		end else if (reqDesc0 || reqDesc1 || reqData) begin
			memReq   <= 1'b1; // Any byte alignment: fetch its word
			memWrite <= 1'b0;
			memBe    <= 4'h0;
			memAddr  <= readAddr[ADDR_W-1:0];
		end else if (reqClose) begin
			memReq   <= 1'b1; // Only the byte holding ready is written
			memWrite <= 1'b1;
			memAddr  <= curPtr[ADDR_W-1:0];
			memWdata <= desc0Raw & ~readyMask;
			memBe    <= readyBe;
		end else if (memReq && memAck) begin
			memReq   <= 1'b0;
			memWrite <= 1'b0;
			memBe    <= 4'h0;
		end
	end

	// Bytes to the transmit FIFO
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txValid <= 1'b0;
			txByte  <= 8'h00;
		end else if (txTaken || !txValid) begin
			txValid <= 1'b0;
			if (state == TBDE_DATA && memAck && !memErr) begin
				txValid <= 1'b1;
				txByte  <= laneByte(memRdata, bufPtr[1:0]);
			end else if (state == TBDE_CRCLO && !txValid) begin
				txValid <= 1'b1; // One idle cycle folds the last data byte in first
				txByte  <= fcs[7:0];
			end else if (next_state == TBDE_CRCHI && txTaken) begin
				txValid <= 1'b1;
				txByte  <= fcs[15:8];
			end else if (next_state == TBDE_FLAG && (txTaken || state == TBDE_FLAG)) begin
				txValid <= state != TBDE_FLAG;
				txByte  <= `TBDE_FLAG_CHAR;
			end else if (next_state == TBDE_PAD && txTaken) begin
				txValid <= 1'b1;
				txByte  <= padChar;
			end
		end
	end

	// Check sequence over the data bytes of one frame
	tbde_crc16 u_crc (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clear   (state == TBDE_EVENT && (lastFlag || errBuf)),
		.enable  (state == TBDE_PUSH && txTaken),
		.dataIn  (txByte),
		.fcs     (fcs)
	);

	// Done event and its counter
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			evtValid <= 1'b0;
			evtAddr  <= '0;
			evCount  <= 32'h0;
		end else begin
			evtValid <= state == TBDE_EVENT && irqFlag;
			if (state == TBDE_EVENT && irqFlag) begin
				evtAddr <= curPtr[ADDR_W-1:0];
				evCount <= evCount + 32'h1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence flagTaken;
		state == TBDE_FLAG && txTaken;
	endsequence
	sequence padsDone;
		state == TBDE_PAD && txTaken && padLeft == 4'h1;
	endsequence

	close_clear_a: assert property (state == TBDE_CLOSE && memReq |-> memWrite
		&& (memWdata & readyMask) == 32'h0) else $error("ready bit not cleared");
	notready_skip_a: assert property (state == TBDE_DESC0 && memAck && !memErr
		&& !d0Ready |=> state == TBDE_IDLE && !txValid) else $error("not-ready sent");
	wrap_base_a: assert property (state == TBDE_EVENT && wrapFlag && enable
		|=> curPtr == descriptor_table_base) else $error("wrap missed");
	event_gate_a: assert property (state == TBDE_EVENT |=> evtValid == $past(irqFlag))
		else $error("event gating wrong");
	crc_select_a: assert property ($rose(state == TBDE_CRCLO) |-> hdlcMode
		&& $past(lastFlag) && $past(crcSel)) else $error("crc on wrong buffer");
	cont_keep_a: assert property (state == TBDE_CLOSE && contFlag && !errBuf
		|-> !memWrite) else $error("continuous buffer closed");
	user_bit_a: assert property (memReq && memWrite |-> memBe == readyBe)
		else $error("user byte written");
	pad_count_a: assert property (padsDone |=> state == TBDE_CLOSE ##[1:1000]
		state == TBDE_EVENT) else $error("pad end wrong");
	pad_zero_a: assert property (flagTaken and (padLeft == 4'h0) |=> state == TBDE_CLOSE)
		else $error("no close after flag");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
		else $error("tx byte dropped");
endmodule : tbde_engine

// >>> shared/tbde_params.svh
// Register map, descriptor field positions, reset values and timing counts
`ifndef TBDE_PARAMS_SVH
`define TBDE_PARAMS_SVH

// Register byte offsets on the control bus
`define TBDE_OFS_CTRL      32'h0000_0000
`define TBDE_OFS_DESCRIPTOR_TABLE_BASE     32'h0000_0004
`define TBDE_OFS_STATUS    32'h0000_0008
`define TBDE_OFS_CURPTR    32'h0000_000C
`define TBDE_OFS_EVCNT     32'h0000_0010

// Control register fields
`define TBDE_CTRL_ENABLE   0
`define TBDE_CTRL_HDLC     1
`define TBDE_CTRL_IDLE     2
`define TBDE_CTRL_REVBITS  3

// Status register fields
`define TBDE_STAT_ERR      16

// Reset values
`define TBDE_CTRL_RST      4'h2
`define TBDE_DESCRIPTOR_TABLE_BASE_RST     32'h0000_0000

// Descriptor word 0 field positions (normal numbering)
`define TBDE_BD_READY      0
`define TBDE_BD_WRAP       2
`define TBDE_BD_IRQ        3
`define TBDE_BD_LAST       4
`define TBDE_BD_CRCSEL     5
`define TBDE_BD_CONT       6
`define TBDE_BD_USER       8
`define TBDE_BD_PAD_LO     12
`define TBDE_BD_LEN_LO     16

// Characters and sizes
`define TBDE_FLAG_CHAR     8'h7E
`define TBDE_IDLE_ONES     8'hFF
`define TBDE_BD_BYTES      32'h0000_0008
`define TBDE_PTR_WORD      32'h0000_0004

// Cycles between two looks at a descriptor that is not ready
`define TBDE_POLL_CYCLES   8'h10

`endif

// >>> shared/tbde_pkg.sv
// Types shared by the transmit descriptor engine
package tbde_pkg;
	// One-hot engine states
	typedef enum logic [10:0] {
		TBDE_IDLE  = 11'b000_0000_0001,
		TBDE_DESC0 = 11'b000_0000_0010,
		TBDE_DESC1 = 11'b000_0000_0100,
		TBDE_DATA  = 11'b000_0000_1000,
		TBDE_PUSH  = 11'b000_0001_0000,
		TBDE_CRCLO = 11'b000_0010_0000,
		TBDE_CRCHI = 11'b000_0100_0000,
		TBDE_FLAG  = 11'b000_1000_0000,
		TBDE_PAD   = 11'b001_0000_0000,
		TBDE_CLOSE = 11'b010_0000_0000,
		TBDE_EVENT = 11'b100_0000_0000
	} tbde_state_t;
endpackage : tbde_pkg

// >>> rtl/tbde_crc16.sv
// Frame check sequence generator, one byte per enabled cycle
`timescale 1ns/1ps
module tbde_crc16 (
	input  wire logic        clk_sys, // System clock
	input  wire logic        rst,     // Synchronous reset, active high
	input  wire logic        clear,   // Preset for a new frame
	input  wire logic        enable,  // Fold in one byte
	input  wire logic [7:0]  dataIn,  // Byte sent on the line
	output logic      [15:0] fcs      // Complemented check value
);
	logic [15:0] crc;
	logic [15:0] next_crc;

	// Reflected polynomial 0x8408, LSB first as sent on the line
	always_comb begin
		next_crc = crc;
		for (int i = 0; i < 8; i++) begin
			if (next_crc[0] ^ dataIn[i]) begin
				next_crc = (next_crc >> 1) ^ 16'h8408;
			end else begin
				next_crc = next_crc >> 1;
			end
		end
	end

	// Running remainder
	always_ff @(posedge clk_sys) begin
		if (rst || clear) begin
			crc <= 16'hFFFF;
		end else if (enable) begin
			crc <= next_crc;
		end
	end

	assign fcs = ~crc;
endmodule : tbde_crc16

// >>> dv/tbde_mem_model.sv
// Memory model holding the descriptor table and the data buffers
`timescale 1ns/1ps
module tbde_mem_model (
	input  wire logic        clk_sys,  // System clock
	input  wire logic        rst,      // Synchronous reset, active high
	input  wire logic        memReq,   // Access pending
	input  wire logic        memWrite, // Access is a write
	input  wire logic [31:0] memAddr,  // Word-aligned byte address
	input  wire logic [31:0] memWdata, // Write data
	input  wire logic [3:0]  memBe,    // Write byte enables
	output logic             memAck,   // Access done
	output logic      [31:0] memRdata, // Read data, valid with ack
	output logic             memErr    // Access failed
);
	logic [31:0] mem [0:255]; // Word store, byte address bits 9:2
	logic [1:0]  waitCnt;     // Cycles left before the answer
	logic [31:0] errAddr = 32'hFFFF_FFFF; // Read address answered with a failure

	// Answers each request after a random wait; idle data lines toggle
	always @(posedge clk_sys) begin
		memErr <= 1'b0;
		if (rst) begin
			memAck   <= 1'b0;
			waitCnt  <= 2'h0;
			memRdata <= 32'h0;
		end else if (memAck || !memReq) begin
			memAck   <= 1'b0;
			memRdata <= ~memRdata;
		end else if (waitCnt != 2'h0) begin
			waitCnt  <= waitCnt - 2'h1;
			memRdata <= ~memRdata;
		end else begin
			memAck  <= 1'b1;
			waitCnt <= 2'($urandom);
			if (memWrite) begin
				for (int b = 0; b < 4; b++)
					if (memBe[b]) mem[memAddr[9:2]][8*b +: 8] <= memWdata[8*b +: 8];
			end else begin
				memRdata <= mem[memAddr[9:2]];
				memErr   <= memAddr == errAddr; // Injected failure, with the ack
			end
		end
	end
endmodule : tbde_mem_model

// >>> dv/tbde_engine_tb.sv
// Self-checking bench for the transmit descriptor engine
`timescale 1ns/1ps
`include "tbde_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tbde_engine_tb;
	localparam logic [31:0] TBA = 32'h0000_0040; // Descriptor table base
	logic        clk_sys = 1'b0, rst = 1'b1, txReady = 1'b0;
	logic [31:0] s_awaddr = 32'h0, s_wdata = 32'h0, s_araddr = 32'h0;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic        s_arvalid = 1'b0, s_rready = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp, resp;
	logic [31:0] s_rdata, rd, memAddr, memWdata, memRdata, evtAddr;
	logic        memReq, memWrite, memAck, memErr, txValid, evtValid, hdlc, idle, rev, bad;
	logic [3:0]  memBe;
	logic [7:0]  txByte, expTx[$], gotTx[$];
	logic [15:0] crc;
	logic [31:0] expEvt[$], gotEvt[$], expW0[0:3], expP[0:3];
	int          expCnt[$], gotCnt[$];
	int          n_mismatch = 0, cmp_count = 0;
	int          nEvt = 0; // Events expected over the whole run

	tbde_engine dut (.clk_sys(clk_sys), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .memReq(memReq),
		.memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memBe(memBe),
		.memAck(memAck), .memRdata(memRdata), .memErr(memErr), .txValid(txValid),
		.txByte(txByte), .txReady(txReady), .evtValid(evtValid), .evtAddr(evtAddr));
	tbde_mem_model mem (.clk_sys(clk_sys), .rst(rst), .memReq(memReq), .memWrite(memWrite),
		.memAddr(memAddr), .memWdata(memWdata), .memBe(memBe), .memAck(memAck),
		.memRdata(memRdata), .memErr(memErr));

	// Clock at 200 MHz
	initial forever #2.5 clk_sys = ~clk_sys;

	// FIFO side with random stalls; records bytes and events
	always @(posedge clk_sys) begin
		txReady <= ($urandom % 4) != 0;
		if (txValid === 1'b1 && txReady === 1'b1) gotTx.push_back(txByte);
		if (evtValid === 1'b1) begin
			gotEvt.push_back(evtAddr);
			gotCnt.push_back(gotTx.size());
		end
	end

	// Register write: address and data offered together, response awaited
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		resp = s_bresp;
		s_bready <= 1'b0;
		@(posedge clk_sys);
	endtask : axi_wr

	// Register read
	task automatic axi_rd(input logic [31:0] a);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		rd   = s_rdata;
		resp = s_rresp;
		s_rready <= 1'b0;
		@(posedge clk_sys);
	endtask : axi_rd

	// Descriptor word in the numbering of the current mode
	function automatic logic [31:0] fmt(input logic [31:0] w);
		return rev ? {<<{w}} : w;
	endfunction : fmt

	// Expected byte with running frame check value
	task automatic push(input logic [7:0] b);
		expTx.push_back(b);
		for (int k = 0; k < 8; k++) crc = (crc[0] ^ b[k]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
	endtask : push

	// Places a descriptor and its random buffer; works out what must follow
	task automatic add_desc(input int i, input logic [31:0] w0);
		logic [7:0]  b;
		logic [15:0] c;
		expP[i] = 32'h100 + 32'(32 * i) + 32'($urandom % 4);
		mem.mem[(TBA >> 2) + 2 * i] = fmt(w0);
		mem.mem[(TBA >> 2) + 2 * i + 1] = expP[i];
		expW0[i] = (w0[6] && !bad) ? fmt(w0) : fmt(w0 & ~32'h1);
		if (bad) mem.errAddr = TBA + 32'(8 * i + 4);
		for (int k = 0; k < (bad ? 0 : int'(w0[31:16])); k++) begin
			b = 8'($urandom);
			mem.mem[(expP[i] + k) >> 2][8 * ((expP[i] + k) % 4) +: 8] = b;
			push(b);
		end
		if (hdlc && w0[4] && !bad) begin
			c = ~crc;
			if (w0[5]) begin
				push(c[7:0]);
				push(c[15:8]);
			end
			push(`TBDE_FLAG_CHAR);
			repeat (w0[15:12]) push(idle ? `TBDE_IDLE_ONES : `TBDE_FLAG_CHAR);
		end
		if (w0[4] || bad) crc = 16'hFFFF;
		if (w0[3]) begin
			nEvt++;
			expEvt.push_back(TBA + 32'(8 * i));
			expCnt.push_back(expTx.size());
		end
	endtask : add_desc

	// Random nonzero byte count
	function automatic logic [15:0] len();
		return 16'(1 + $urandom % 8);
	endfunction : len

	// Waits for the traffic, lets the engine idle, then compares everything
	task automatic run_check();
		for (int t = 0; t < 4000 && (gotTx.size() < expTx.size()
			|| gotEvt.size() < expEvt.size()); t++)
			@(posedge clk_sys);
		repeat (80) @(posedge clk_sys);
		`CHK("tx count", expTx.size(), gotTx.size())
		for (int k = 0; k < expTx.size() && k < gotTx.size(); k++)
			`CHK("tx byte", expTx[k], gotTx[k])
		`CHK("event count", expEvt.size(), gotEvt.size())
		for (int k = 0; k < expEvt.size() && k < gotEvt.size(); k++) begin
			`CHK("event addr", expEvt[k], gotEvt[k])
			`CHK("event position", expCnt[k], gotCnt[k])
		end
		for (int k = 0; k < 4; k++) begin
			`CHK("desc word", expW0[k], mem.mem[(TBA >> 2) + 2 * k])
			`CHK("buffer pointer", expP[k], mem.mem[(TBA >> 2) + 2 * k + 1])
		end
		expTx.delete();
		gotTx.delete();
		expEvt.delete();
		gotEvt.delete();
		expCnt.delete();
		gotCnt.delete();
	endtask : run_check

	// Verdict and end of run
	task automatic end_of_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_mismatch++;
		end_of_test();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h9549));
		crc = 16'hFFFF;
		{hdlc, idle, rev, bad} = 4'b1000;
		for (int k = 0; k < 256; k++) mem.mem[k] = 32'h0;
		for (int k = 0; k < 4; k++) {expW0[k], expP[k]} = 64'h0;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		axi_rd(`TBDE_OFS_CTRL);
		`CHK("ctrl reset", {28'h0, `TBDE_CTRL_RST}, rd)
		axi_rd(`TBDE_OFS_DESCRIPTOR_TABLE_BASE);
		`CHK("base reset", `TBDE_DESCRIPTOR_TABLE_BASE_RST, rd)
		axi_rd(32'h0000_0020);
		`CHK("unmapped read", 2'b10, resp)
		axi_wr(32'h0000_0014, 32'h1);
		`CHK("unmapped write", 2'b10, resp)
		axi_wr(`TBDE_OFS_DESCRIPTOR_TABLE_BASE, TBA);
		axi_rd(`TBDE_OFS_DESCRIPTOR_TABLE_BASE);
		`CHK("table base", TBA, rd)
		// Two-buffer frame with CRC, then a padless frame on the wrap entry
		add_desc(0, {len(), 16'h0121});
		add_desc(1, {len(), 16'h2139});
		add_desc(2, {len(), 16'h001D});
		axi_wr(`TBDE_OFS_CTRL, 32'h3);
		run_check();
		// Resume at the first entry after wrap; continuous, ones padding
		idle = 1'b1;
		axi_wr(`TBDE_OFS_CTRL, 32'h7);
		add_desc(0, {len(), 16'h1059});
		run_check();
		// Transparent mode ignores CRC request and padding
		hdlc = 1'b0;
		axi_wr(`TBDE_OFS_CTRL, 32'h1);
		add_desc(1, {len(), 16'h3039});
		// Pointer fetch fails: closed with ready cleared despite continuous mode
		bad = 1'b1;
		add_desc(2, {len(), 16'h0049});
		bad = 1'b0;
		run_check();
		axi_rd(`TBDE_OFS_STATUS);
		`CHK("error flag", 1'b1, rd[`TBDE_STAT_ERR])
		axi_wr(`TBDE_OFS_STATUS, 32'h0001_0000);
		axi_rd(`TBDE_OFS_STATUS);
		`CHK("error clear", 1'b0, rd[`TBDE_STAT_ERR])
		mem.errAddr = 32'hFFFF_FFFF;
		// Stop the engine before touching the still-ready entry; reversed numbering
		axi_wr(`TBDE_OFS_CTRL, 32'h0);
		{hdlc, rev} = 2'b11;
		add_desc(0, {len(), 16'h003D});
		axi_wr(`TBDE_OFS_CTRL, 32'hB);
		run_check();
		axi_rd(`TBDE_OFS_EVCNT);
		`CHK("event counter", 32'(nEvt), rd)
		end_of_test();
	end
endmodule : tbde_engine_tb
